// ### pmrc_ctrl.v
// Power-mode and reset controller: NO-POWER, RTC, RESET and shutdown handling.
// Assumes a 40 MHz ref_clk from the internal oscillator, analog comparators as
// synchronous level inputs, and an APB master for the register file.
`timescale 1ns/1ps
`default_nettype none
`include "pmrc_map.vh"
module pmrc_ctrl #(
   parameter LONG_PRESS_CYC = `PMRC_LONG_PRESS_CYC,
   parameter CANCEL_CYC     = `PMRC_CANCEL_CYC,
   parameter WDG_CYC        = `PMRC_WDG_CYC,
   parameter STEP_CYC       = `PMRC_STEP_CYC,
   parameter SEQ_STEPS      = `PMRC_SEQ_STEPS
) (
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        power_key_n,
   input  wire        reset_request_n,
   input  wire        vsys_above_por,
   input  wire        vsys_below_por_low,
   input  wire        vsys_undervoltage,
   input  wire        supply_fault,
   input  wire        battery_only,
   input  wire        rtc_request,
   input  wire        rtc_alarm,
   input  wire        over_temp,
   input  wire        watchdog_service,
   input  wire        powerdown_req,
   input  wire        wakeup_req,
   input  wire        otp_abort,
   input  wire        otp_done,
   output reg         system_reset_out_n,
   output reg         interrupt_out_n,
   output reg         por_out,
   output reg         otp_reload,
   output reg         event_clear,
   output reg         gpio_enable,
   output reg         always_on_ldo_en,
   output reg         regulators_en,
   output reg         core_ldo_reduced,
   output reg  [3:0]  seq_position,
   output reg  [2:0]  power_mode
);
   localparam [2:0] ST_NOPOWER = 3'h0;
   localparam [2:0] ST_RTC     = 3'h1;
   localparam [2:0] ST_RESET   = 3'h2;
   localparam [2:0] ST_PDOWN   = 3'h3;
   localparam [2:0] ST_ACTIVE  = 3'h4;
   localparam [2:0] ST_SHUT    = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation and edge detection.
   wire key_s_n;
   wire rreq_s_n;
   reg  rreq_d_n;

   pmrc_sync #(.RESET_VAL(1'b1)) u_key_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (power_key_n),
      .dout    (key_s_n)
   );
   pmrc_sync #(.RESET_VAL(1'b1)) u_rreq_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .din     (reset_request_n),
      .dout    (rreq_s_n)
   );

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rreq_d_n <= 1'b1;
      end else begin
         rreq_d_n <= rreq_s_n;
      end
   end

   wire rreq_fall = rreq_d_n & ~rreq_s_n;

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   reg [7:0]  ctrl;
   reg [5:0]  fault_log;
   reg [31:0] key_time;
   reg [2:0]  state;
   reg [31:0] press_cnt;
   reg [31:0] cancel_cnt;
   reg [31:0] wdg_cnt;
   reg [31:0] step_cnt;
   reg        key_pending;
   reg        fast;
   reg        key_por;
   reg        host_sd_pulse;

   wire apb_acc   = psel & penable;
   wire apb_wr    = apb_acc & pwrite;
   wire addr_ok   = (paddr == `PMRC_ADDR_CTRL) | (paddr == `PMRC_ADDR_SHUTDOWN) |
                    (paddr == `PMRC_ADDR_FAULT_LOG) | (paddr == `PMRC_ADDR_STATUS) |
                    (paddr == `PMRC_ADDR_KEY_TIME);
   wire log_wr    = apb_wr & (paddr == `PMRC_ADDR_FAULT_LOG);
   wire [5:0] log_clr = log_wr ? pwdata[5:0] : 6'h00;

   wire powered   = (state == ST_PDOWN) | (state == ST_ACTIVE);
   wire wdg_en    = ctrl[`PMRC_CTRL_WDG_EN];
   wire wdg_fault = powered & wdg_en & (wdg_cnt >= WDG_CYC);
   wire int_fault = powered & (wdg_fault | vsys_undervoltage | over_temp);
   wire ext_trig  = powered & rreq_fall;
   wire host_trig = powered & host_sd_pulse;
   wire hard_trig = int_fault | ext_trig | host_trig;
   wire key_long  = powered & ~key_s_n & (press_cnt >= key_time) & ~key_pending;
   wire key_done  = key_pending & (cancel_cnt >= CANCEL_CYC);
   wire rtc_auto  = ctrl[`PMRC_CTRL_RTC_DOM] &
                    ((supply_fault & ctrl[`PMRC_CTRL_RTC_SF]) | vsys_below_por_low);
   wire step_tick = (step_cnt >= STEP_CYC - 1);
   // Settings reload on the very edge that leaves RESET, so POWERDOWN never acts on stale ones.
   wire reset_exit = (state == ST_RESET) & ~(rtc_auto | battery_only | rtc_request) &
                     ~otp_abort & otp_done & rreq_s_n & vsys_above_por & ~vsys_undervoltage;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave; every access completes in its first access cycle.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl          <= `PMRC_CTRL_RESET;
         key_time      <= LONG_PRESS_CYC;
         host_sd_pulse <= 1'b0;
         prdata        <= 32'h0000_0000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
      end else begin
         host_sd_pulse <= 1'b0;
         pready        <= psel & ~penable;
         pslverr       <= psel & ~penable & ~addr_ok;
         if (psel & ~penable) begin
            case (paddr)
               `PMRC_ADDR_CTRL:      prdata <= {24'h000000, ctrl};
               `PMRC_ADDR_FAULT_LOG: prdata <= {26'h0000000, fault_log};
               `PMRC_ADDR_STATUS:    prdata <= {21'h000000, seq_position, key_pending,
                                               ~key_s_n, ~rreq_s_n, 1'b0, state};
               `PMRC_ADDR_KEY_TIME:  prdata <= key_time;
               default:              prdata <= 32'h0000_0000;
            endcase
         end
         if (apb_wr & pready) begin
            if (paddr == `PMRC_ADDR_CTRL) begin
               ctrl <= pwdata[7:0];
            end
            if (paddr == `PMRC_ADDR_KEY_TIME) begin
               key_time <= pwdata;
            end
            if ((paddr == `PMRC_ADDR_SHUTDOWN) & pwdata[0]) begin
               host_sd_pulse <= 1'b1;
            end
         end
         if (reset_exit) begin
            ctrl     <= `PMRC_CTRL_RESET;
            key_time <= LONG_PRESS_CYC;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault-cause log; a cause raised in the clearing cycle survives.
   reg [5:0] log_set;
   always @* begin
      log_set = 6'h00;
      log_set[`PMRC_LOG_KEY]  = key_long & ~hard_trig;
      log_set[`PMRC_LOG_EXT]  = ext_trig;
      log_set[`PMRC_LOG_WDG]  = wdg_fault;
      log_set[`PMRC_LOG_UV]   = powered & vsys_undervoltage;
      log_set[`PMRC_LOG_OT]   = powered & over_temp;
      log_set[`PMRC_LOG_HOST] = host_trig;
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fault_log <= 6'h00;
      end else begin
         fault_log <= (fault_log & ~(log_clr & {6{pready}})) | log_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters: key press duration, cancel window, watchdog, sequencer step.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         press_cnt  <= 32'h0000_0000;
         cancel_cnt <= 32'h0000_0000;
         wdg_cnt    <= 32'h0000_0000;
         step_cnt   <= 32'h0000_0000;
      end else begin
         press_cnt  <= key_s_n ? 32'h0000_0000 : press_cnt + 32'h1;
         cancel_cnt <= key_pending ? cancel_cnt + 32'h1 : 32'h0000_0000;
         if (watchdog_service | ~powered | ~wdg_en) begin
            wdg_cnt <= 32'h0000_0000;
         end else if (~wdg_fault) begin
            wdg_cnt <= wdg_cnt + 32'h1;
         end
         step_cnt <= (state != ST_SHUT | step_tick) ? 32'h0000_0000 : step_cnt + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-mode state machine.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state        <= ST_NOPOWER;
         key_pending  <= 1'b0;
         fast         <= 1'b0;
         key_por      <= 1'b0;
         seq_position <= 4'h0;
         otp_reload   <= 1'b0;
         event_clear  <= 1'b0;
         por_out      <= 1'b0;
         interrupt_out_n    <= 1'b1;
         system_reset_out_n <= 1'b0;
      end else begin
         otp_reload  <= 1'b0;
         event_clear <= 1'b0;
         por_out     <= 1'b0;
         if (key_pending & log_clr[`PMRC_LOG_KEY] & pready & ~key_long) begin
            key_pending     <= 1'b0;
            interrupt_out_n <= 1'b1;
         end
         case (state)
            ST_NOPOWER: begin
               if (vsys_above_por) begin
                  state       <= ST_RESET;
                  event_clear <= 1'b1;
               end
            end
            ST_RTC: begin
               system_reset_out_n <= 1'b0;
               if ((vsys_above_por & ~battery_only & ~rtc_auto) | ~key_s_n | rtc_alarm) begin
                  state       <= ST_RESET;
                  event_clear <= 1'b1;
               end
            end
            ST_RESET: begin
               system_reset_out_n <= 1'b0;
               key_pending        <= 1'b0;
               interrupt_out_n    <= 1'b1;
               if (rtc_auto | battery_only | rtc_request) begin
                  state <= ST_RTC;
               end else if (otp_abort) begin
                  state <= ST_RESET;
               end else if (otp_done & rreq_s_n & vsys_above_por & ~vsys_undervoltage) begin
                  state      <= ST_PDOWN;
                  otp_reload <= 1'b1;
               end
            end
            ST_PDOWN, ST_ACTIVE: begin
               system_reset_out_n <= 1'b1;
               if (hard_trig | key_done) begin
                  system_reset_out_n <= 1'b0;
                  key_pending        <= 1'b0;
                  interrupt_out_n    <= 1'b1;
                  key_por            <= ~hard_trig & ctrl[`PMRC_CTRL_KEY_FAST];
                  fast <= int_fault ? ctrl[`PMRC_CTRL_INT_FAST] :
                          (ext_trig | host_trig) ? ctrl[`PMRC_CTRL_HOST_FAST] :
                          ctrl[`PMRC_CTRL_KEY_FAST];
                  state <= ST_SHUT;
                  seq_position <= (state == ST_ACTIVE) ? SEQ_STEPS[3:0] : 4'h0;
               end else if (key_long) begin
                  key_pending     <= 1'b1;
                  interrupt_out_n <= 1'b0;
               end else if (rtc_auto | battery_only | rtc_request |
                            (state == ST_PDOWN & ctrl[`PMRC_CTRL_RTC_PD])) begin
                  state <= ST_RTC;
               end else if (state == ST_PDOWN & wakeup_req) begin
                  state <= ST_ACTIVE;
               end else if (state == ST_ACTIVE & powerdown_req) begin
                  state <= ST_PDOWN;
               end
            end
            ST_SHUT: begin
               system_reset_out_n <= 1'b0;
               if (fast | seq_position == 4'h0) begin
                  seq_position <= 4'h0;
                  if (key_por) begin
                     state   <= ST_NOPOWER;
                     por_out <= 1'b1;
                  end else begin
                     state <= ST_RESET;
                  end
                  event_clear <= 1'b1;
               end else if (step_tick) begin
                  seq_position <= seq_position - 4'h1;
               end
            end
            default: begin
               state <= ST_NOPOWER;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supply and function enables follow the mode.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         gpio_enable      <= 1'b0;
         always_on_ldo_en <= 1'b0;
         regulators_en    <= 1'b0;
         core_ldo_reduced <= 1'b0;
         power_mode       <= ST_NOPOWER;
      end else begin
         power_mode       <= state;
         gpio_enable      <= (state != ST_RTC) & (state != ST_NOPOWER);
         regulators_en    <= (state == ST_ACTIVE) | (state == ST_SHUT & ~fast);
         always_on_ldo_en <= (state == ST_RESET | powered | state == ST_SHUT) &
                             ctrl[`PMRC_CTRL_AON_LDO];
         core_ldo_reduced <= (state == ST_RESET);
      end
   end
endmodule // pmrc_ctrl
`default_nettype wire

// ### pmrc_ctrl_asserts.sv
// Checker for the power-mode controller, watching only its ports.
// Assumes power_mode codes 0 no power, 1 rtc, 2 reset, 5 shutdown.
`timescale 1ns/1ps
`default_nettype none
module pmrc_ctrl_asserts (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        vsys_above_por,
   input wire logic        system_reset_out_n,
   input wire logic        event_clear,
   input wire logic        gpio_enable,
   input wire logic        always_on_ldo_en,
   input wire logic        regulators_en,
   input wire logic        core_ldo_reduced,
   input wire logic [3:0]  seq_position,
   input wire logic [2:0]  power_mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence enter_reset;
      power_mode != 3'h2 ##1 power_mode == 3'h2;
   endsequence
   a_apb_answer: assert property (apb_setup |=> pready)
      else $error("pready missing after setup");
   a_unmapped_err: assert property (apb_setup ##0 (!pwrite && paddr > 12'h010)
      |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
   a_seq_at_zero: assert property (enter_reset |-> seq_position == 4'h0)
      else $error("reset entered with sequencer not at zero");
   // The mode output lags the state by one cycle, so the clear pulse comes first.
   a_events_cleared: assert property (enter_reset |-> $past(event_clear))
      else $error("no event clear on reset entry");
   a_reset_out_low: assert property (power_mode inside {3'h2, 3'h5}
      |-> !system_reset_out_n) else $error("reset output high in shutdown or reset");
   a_reset_supplies: assert property (power_mode == 3'h2 [*2]
      |-> !regulators_en && core_ldo_reduced) else $error("regulators on in reset mode");
   a_rtc_quiet: assert property (power_mode == 3'h1
      |-> !gpio_enable && !regulators_en && !always_on_ldo_en) else $error("rtc mode not quiet");
   a_por_to_reset: assert property ($rose(vsys_above_por) && power_mode == 3'h0
      |-> ##[1:4] power_mode == 3'h2) else $error("no reset after supply rise");
endmodule // pmrc_ctrl_asserts
bind pmrc_ctrl pmrc_ctrl_asserts chk_u (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .vsys_above_por, .system_reset_out_n, .event_clear,
   .gpio_enable, .always_on_ldo_en, .regulators_en, .core_ldo_reduced, .seq_position,
   .power_mode);
`default_nettype wire

// ### pmrc_far_model.sv
// Far-side model: power key, reset switch and the host's watchdog service.
// Assumes bench commands that change just after a rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none
module pmrc_far_model (
   input  wire logic ref_clk,
   input  wire logic key_down,
   input  wire logic sw_down,
   input  wire logic svc_on,
   output var  logic power_key_n,
   output var  logic reset_request_n,
   output var  logic watchdog_service
);
   logic [3:0] svc_cnt = 4'h0;
   // A short service pulse every 16 cycles keeps well inside the shortened window.
   always @(posedge ref_clk) begin
      power_key_n <= !key_down;
      reset_request_n <= !sw_down;
      svc_cnt <= svc_cnt + 4'h1;
      watchdog_service <= svc_on && (svc_cnt == 4'hf);
   end
endmodule // pmrc_far_model
`default_nettype wire

// ### pmrc_map.vh
// Register map, field positions, reset values and timing counts of the power-mode controller.
// Assumes a 40 MHz reference clock and an APB slave with 32-bit data.
`ifndef PMRC_MAP_VH
`define PMRC_MAP_VH

`define PMRC_CLK_HZ            40000000
`define PMRC_ADDR_CTRL         12'h000
`define PMRC_ADDR_SHUTDOWN     12'h004
`define PMRC_ADDR_FAULT_LOG    12'h008
`define PMRC_ADDR_STATUS       12'h00c
`define PMRC_ADDR_KEY_TIME     12'h010

`define PMRC_CTRL_RTC_PD       0
`define PMRC_CTRL_RTC_SF       1
`define PMRC_CTRL_RTC_DOM      2
`define PMRC_CTRL_INT_FAST     3
`define PMRC_CTRL_HOST_FAST    4
`define PMRC_CTRL_KEY_FAST     5
`define PMRC_CTRL_AON_LDO      6
`define PMRC_CTRL_WDG_EN       7
`define PMRC_CTRL_RESET        8'h44

`define PMRC_LOG_KEY           0
`define PMRC_LOG_EXT           1
`define PMRC_LOG_WDG           2
`define PMRC_LOG_UV            3
`define PMRC_LOG_OT            4
`define PMRC_LOG_HOST          5

`define PMRC_CANCEL_MS         1000
`define PMRC_CANCEL_CYC        (`PMRC_CLK_HZ / 1000 * `PMRC_CANCEL_MS)
`define PMRC_LONG_PRESS_MS     4000
`define PMRC_LONG_PRESS_CYC    (`PMRC_CLK_HZ / 1000 * `PMRC_LONG_PRESS_MS)
`define PMRC_WDG_MS            2000
`define PMRC_WDG_CYC           (`PMRC_CLK_HZ / 1000 * `PMRC_WDG_MS)
`define PMRC_STEP_US           32
`define PMRC_STEP_CYC          (`PMRC_CLK_HZ / 1000000 * `PMRC_STEP_US)
`define PMRC_SEQ_STEPS         15

`endif

// ### pmrc_sync.v
// Two-flop synchroniser for one level input.
// Assumes the input may change at any time relative to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module pmrc_sync #(
   parameter RESET_VAL = 1'b1
) (
   input  wire ref_clk,
   input  wire nrst,
   input  wire din,
   output reg  dout
);
   reg meta;

   // The first flop feeds only the second; nothing else looks at it.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta <= RESET_VAL;
         dout <= RESET_VAL;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // pmrc_sync
`default_nettype wire

// ### tb_pmrc_ctrl.sv
// Bench for the power-mode controller: APB host, supplies, faults, key and reset switch.
// Assumes the shortened counts below and the far-side model for the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_pmrc_ctrl;
   localparam int STEP = 4;
   logic        ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, prd, seed = 32'h104c0226;
   logic        pready, pslverr, perr, power_key_n, reset_request_n, watchdog_service;
   logic        vsys_above_por = 0, vsys_below_por_low = 0, vsys_undervoltage = 0;
   logic        supply_fault = 0, battery_only = 0, rtc_request = 0, rtc_alarm = 0;
   logic        over_temp = 0, powerdown_req = 0, wakeup_req = 0, otp_abort = 0, otp_done = 0;
   logic        key_down = 0, sw_down = 0, svc_on = 1, por_seen = 0;
   logic        system_reset_out_n, interrupt_out_n, por_out, otp_reload, event_clear;
   logic        gpio_enable, always_on_ldo_en, regulators_en, core_ldo_reduced;
   logic [3:0]  seq_position;
   logic [2:0]  power_mode;
   int          error_cnt = 0, samples_checked = 0, waited;
   pmrc_ctrl #(.LONG_PRESS_CYC(20), .CANCEL_CYC(20), .WDG_CYC(50), .STEP_CYC(STEP),
      .SEQ_STEPS(15)) dut_u (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .power_key_n, .reset_request_n, .vsys_above_por,
      .vsys_below_por_low, .vsys_undervoltage, .supply_fault, .battery_only, .rtc_request,
      .rtc_alarm, .over_temp, .watchdog_service, .powerdown_req, .wakeup_req, .otp_abort,
      .otp_done, .system_reset_out_n, .interrupt_out_n, .por_out, .otp_reload, .event_clear,
      .gpio_enable, .always_on_ldo_en, .regulators_en, .core_ldo_reduced, .seq_position,
      .power_mode);
   pmrc_far_model far_u (.ref_clk, .key_down, .sw_down, .svc_on, .power_key_n,
      .reset_request_n, .watchdog_service);
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // The pulse lasts one cycle, so it is caught here rather than polled.
   always @(posedge ref_clk) if (por_out === 1'b1) por_seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   function automatic logic hit(input int k, input logic [2:0] m);
      return k == 0 ? power_mode === m : k == 1 ? interrupt_out_n === 1'b0 : power_mode !== m;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      prd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(prd, e);
   endtask
   task automatic wait_for(input int k, input logic [2:0] m);
      waited = 0;
      while (!hit(k, m) && waited < 400) begin
         @(posedge ref_clk);
         waited++;
      end
      chk(32'(hit(k, m)), 32'h1);
   endtask
   task automatic to_active;
      otp_done <= 1'b1;
      wait_for(0, 3'h3);
      otp_done <= 1'b0;
      wakeup_req <= 1'b1;
      wait_for(0, 3'h4);
      wakeup_req <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge ref_clk);
      chk(32'({system_reset_out_n, interrupt_out_n, power_mode}), 32'h08);
      nrst <= 1'b1;
      vsys_above_por <= 1'b1;
      wait_for(0, 3'h2);
      rd(12'h000, 32'h44);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         apb(1'b1, 12'h014 + {seed[9:2], 2'b00}, seed);
         chk(32'(perr), 32'h1);
      end
      rd(12'h014 + {seed[9:2], 2'b00}, 32'h0);
      chk(32'(perr), 32'h1);
      apb(1'b1, 12'h000, seed & 32'h38);
      otp_abort <= 1'b1;
      repeat (8) @(posedge ref_clk);
      otp_abort <= 1'b0;
      chk(32'(power_mode), 32'h2);
      rd(12'h008, 32'h0);
      $display("test power-up done");
      to_active;
      rd(12'h000, 32'h44);
      apb(1'b1, 12'h000, 32'h54);
      apb(1'b1, 12'h004, 32'h1);
      wait_for(0, 3'h2);
      chk(32'(waited < 8), 32'h1);
      rd(12'h008, 32'h20);
      apb(1'b1, 12'h008, 32'h20);
      rd(12'h008, 32'h0);
      $display("test host shutdown done");
      // Key fast-off is set so that a wrongly chosen key shutdown would end in a power-on reset.
      to_active;
      apb(1'b1, 12'h000, 32'h64);
      apb(1'b1, 12'h010, 32'd20);
      key_down <= 1'b1;
      wait_for(1, 3'h0);
      key_down <= 1'b0;
      sw_down <= 1'b1;
      wait_for(0, 3'h5);
      chk(32'(system_reset_out_n), 32'h0);
      wait_for(0, 3'h2);
      chk(32'(waited >= 14 * STEP), 32'h1);
      rd(12'h008, 32'h3);
      apb(1'b1, 12'h008, 32'h3);
      sw_down <= 1'b0;
      $display("test reset switch done");
      to_active;
      apb(1'b1, 12'h010, 32'd20);
      for (int i = 0; i < 2; i++) begin
         key_down <= 1'b1;
         wait_for(1, 3'h0);
         key_down <= 1'b0;
         rd(12'h008, 32'h1);
         if (i == 0) apb(1'b1, 12'h008, 32'h1);
         repeat (40) @(posedge ref_clk);
         wait_for(0, i ? 3'h2 : 3'h4);
      end
      apb(1'b1, 12'h008, 32'h1);
      to_active;
      apb(1'b1, 12'h000, 32'h64);
      apb(1'b1, 12'h010, 32'd20);
      key_down <= 1'b1;
      wait_for(0, 3'h0);
      key_down <= 1'b0;
      chk(32'(por_seen), 32'h1);
      wait_for(0, 3'h2);
      apb(1'b1, 12'h008, 32'h3f);
      $display("test key press done");
      for (int i = 0; i < 3; i++) begin
         to_active;
         apb(1'b1, 12'h000, i == 2 ? 32'hc4 : 32'h4c);
         repeat (150) @(posedge ref_clk);
         chk(32'(power_mode), 32'h4);
         over_temp <= i == 0;
         vsys_undervoltage <= i == 1;
         svc_on <= i != 2;
         wait_for(0, 3'h2);
         chk(32'(i != 0 || waited < 8), 32'h1);
         over_temp <= 1'b0;
         vsys_undervoltage <= 1'b0;
         svc_on <= 1'b1;
         rd(12'h008, 32'h10 >> i);
         apb(1'b1, 12'h008, 32'h10 >> i);
      end
      $display("test faults done");
      // The supply fault stays up while the alarm is raised, so only the alarm or the power key can wake it.
      to_active;
      apb(1'b1, 12'h000, 32'h46);
      supply_fault <= 1'b1;
      wait_for(0, 3'h1);
      chk(32'(gpio_enable), 32'h0);
      rtc_alarm <= 1'b1;
      wait_for(2, 3'h1);
      rtc_alarm <= 1'b0;
      supply_fault <= 1'b0;
      wait_for(0, 3'h2);
      to_active;
      apb(1'b1, 12'h000, 32'h45);
      powerdown_req <= 1'b1;
      wait_for(0, 3'h1);
      powerdown_req <= 1'b0;
      wait_for(0, 3'h2);
      rtc_request <= 1'b1;
      wait_for(0, 3'h1);
      rtc_request <= 1'b0;
      wait_for(0, 3'h2);
      $display("test rtc done");
      complete_run;
   end
   initial begin
      #750us;
      error_cnt++;
      complete_run;
   end
endmodule // tb_pmrc_ctrl
`default_nettype wire
